// file: design/rst_irq_pkg.sv
// Constants for reset sequencing and interrupt dispatch
package rst_irq_pkg;
   localparam int          RESET_DELAY_CYCLES = 2048;
   localparam int          FETCH_CYCLES       = 2;
   localparam logic [11:0] RESET_VECTOR       = 12'hFFE;
   localparam logic [11:0] NMI_VECTOR         = 12'hFFC;
   localparam logic [11:0] VEC1_ADDR          = 12'hFF6;
   localparam logic [11:0] VEC2_ADDR          = 12'hFF4;
   localparam logic [11:0] VEC3_ADDR          = 12'hFF2;
   localparam logic [11:0] VEC4_ADDR          = 12'hFF0;
   localparam int          OPT_IRQ_EN_BIT     = 4;
   localparam int          OPT_RISE_BIT       = 5;
   localparam int          OPT_LEVEL_BIT      = 6;
   localparam logic [7:0]  OPT_RESET          = 8'h00;
   localparam logic [3:0]  STOP_CAPABLE       = 4'h7;
   localparam int          WDG_PULSE_CYCLES   = 4;
   localparam logic [1:0]  ADDR_OPTION        = 2'h0;
   localparam logic [1:0]  ADDR_STATUS        = 2'h1;
   localparam logic [1:0]  ADDR_PERIPH_EN     = 2'h2;
   localparam logic [1:0]  ADDR_PERIPH_FLAG   = 2'h3;
   typedef enum logic [2:0] {
      ST_HOLD  = 3'b001,
      ST_DELAY = 3'b010,
      ST_FETCH = 3'b100
   } rst_state_t;
endpackage

// file: design/pin_sync.sv
// Three-flop synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
   parameter logic INIT = 1'b1
) (
   input  wire logic i_mclk,
   input  wire logic i_rst,
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_fall
);
   logic [2:0] stage_reg;
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         stage_reg <= {3{INIT}};
         o_level   <= INIT;
      end else begin
         stage_reg <= {stage_reg[1:0], i_pin};
         if (stage_reg[1] == stage_reg[2]) begin
            o_level <= stage_reg[2];
         end
      end
   end
   assign o_fall = o_level && (stage_reg[1] == stage_reg[2]) && !stage_reg[2];
endmodule

// file: design/reset_and_interrupt_control.sv
// Reset sequencer and interrupt arbiter for a small 8-bit core
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps
module reset_and_interrupt_control #(
   parameter int RESET_DELAY = rst_irq_pkg::RESET_DELAY_CYCLES,
   parameter int EXT_LINES   = 6,
   parameter int TIMER_SRC   = 1,
   parameter int ADC_SRC     = 1
) (
   input  wire logic                 i_mclk,
   input  wire logic                 i_rst,
   input  wire logic                 i_reset_pin_n,
   output logic                      o_reset_pin_n_out,
   output logic                      o_reset_pin_oe,
   input  wire logic                 i_wdg_reset,
   input  wire logic                 i_supply_voltage_monitor,
   input  wire logic                 i_nmi_pin_n,
   input  wire logic [EXT_LINES-1:0] i_ext1_n,
   input  wire logic [EXT_LINES-1:0] i_ext2,
   input  wire logic [TIMER_SRC-1:0] i_timer_evt,
   input  wire logic [ADC_SRC-1:0]   i_adc_evt,
   input  wire logic                 i_wait_mode,
   input  wire logic                 i_stop_mode,
   input  wire logic                 i_return_from_interrupt_instr,
   input  wire logic [1:0]           i_addr,
   input  wire logic [7:0]           i_wdata,
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   output logic [7:0]                o_rdata,
   output logic                      o_core_reset,
   output logic                      o_stack_clear,
   output logic                      o_ports_pullup,
   output logic                      o_osc_restart,
   output logic                      o_pc_load,
   output logic [11:0]               o_pc_vector,
   output logic                      o_nmi_mode,
   output logic                      o_irq_mode,
   output logic                      o_wake
);
   // ==========================================================
   // Parameter checks
   if (RESET_DELAY < 2 || RESET_DELAY > 65535 || EXT_LINES < 1 ||
       TIMER_SRC < 1 || ADC_SRC < 1) begin : g_param_check
      $error("reset_and_interrupt_control: unsupported parameter");
   end

   // ==========================================================
   // Pin synchronisers
   logic              rst_pin_lvl;
   logic              nmi_fall;
   logic              nmi_lvl;
   logic [EXT_LINES-1:0] ext1_lvl;
   logic [EXT_LINES-1:0] ext2_lvl;
   logic [EXT_LINES-1:0] ext1_prev_reg;
   logic [EXT_LINES-1:0] ext2_prev_reg;

   pin_sync #(.INIT(1'b1)) u_rst_sync (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_pin  (i_reset_pin_n),
      .o_level(rst_pin_lvl),
      .o_fall ()
   );
   pin_sync #(.INIT(1'b1)) u_nmi_sync (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_pin  (i_nmi_pin_n),
      .o_level(nmi_lvl),
      .o_fall (nmi_fall)
   );
   genvar g;
   generate
      for (g = 0; g < EXT_LINES; g++) begin : g_ext
         pin_sync #(.INIT(1'b1)) u_e1 (
            .i_mclk (i_mclk),
            .i_rst  (i_rst),
            .i_pin  (i_ext1_n[g]),
            .o_level(ext1_lvl[g]),
            .o_fall ()
         );
         pin_sync #(.INIT(1'b1)) u_e2 (
            .i_mclk (i_mclk),
            .i_rst  (i_rst),
            .i_pin  (i_ext2[g]),
            .o_level(ext2_lvl[g]),
            .o_fall ()
         );
      end
   endgenerate

   // ==========================================================
   // Registers
   logic [7:0]           option_reg;
   logic [1:0]           periph_en_reg;
   logic [1:0]           periph_flag_reg;
   logic                 global_irq_enable;
   logic                 level_mode;
   logic                 rise_mode;
   assign global_irq_enable = option_reg[rst_irq_pkg::OPT_IRQ_EN_BIT];
   assign level_mode        = option_reg[rst_irq_pkg::OPT_LEVEL_BIT];
   assign rise_mode         = option_reg[rst_irq_pkg::OPT_RISE_BIT];

   // ==========================================================
   // Reset sequencer
   rst_irq_pkg::rst_state_t state_reg;
   logic [15:0]             dly_reg;
   logic [1:0]              fetch_reg;
   logic [2:0]              wdg_cnt_reg;
   logic                    running_reg;
   logic                    rst_event;
   logic                    rst_hold;
   localparam logic [15:0] DLY_LAST = 16'(RESET_DELAY - 1);
   localparam logic [1:0]  FETCH_LAST = 2'(rst_irq_pkg::FETCH_CYCLES - 1);

   // Our own pull on the pin is sensed too; it only stretches the reset,
   // which restarts the delay, so no separate filtering is needed
   assign rst_hold  = !rst_pin_lvl || i_supply_voltage_monitor;
   assign rst_event = rst_hold || i_wdg_reset;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_reg <= rst_irq_pkg::ST_HOLD;
         dly_reg   <= 16'h0000;
         fetch_reg <= 2'h0;
      end else begin
         case (state_reg)
            rst_irq_pkg::ST_HOLD: begin
               dly_reg <= 16'h0000;
               // A running core must not fall back into the delay
               if (!rst_event && !running_reg) begin
                  state_reg <= rst_irq_pkg::ST_DELAY;
               end
            end
            rst_irq_pkg::ST_DELAY: begin
               if (rst_event) begin
                  state_reg <= rst_irq_pkg::ST_HOLD;
                  dly_reg   <= 16'h0000;
               end else if (dly_reg == DLY_LAST) begin
                  state_reg <= rst_irq_pkg::ST_FETCH;
                  fetch_reg <= 2'h0;
               end else begin
                  dly_reg <= dly_reg + 16'h0001;
               end
            end
            rst_irq_pkg::ST_FETCH: begin
               if (rst_event) begin
                  state_reg <= rst_irq_pkg::ST_HOLD;
               end else if (fetch_reg == FETCH_LAST) begin
                  state_reg <= rst_irq_pkg::ST_HOLD;
               end else begin
                  fetch_reg <= fetch_reg + 2'h1;
               end
            end
            default: state_reg <= rst_irq_pkg::ST_HOLD;
         endcase
         // Running state: hold idles with dly zero once fetch done
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         running_reg <= 1'b0;
      end else if (rst_event) begin
         running_reg <= 1'b0;
      end else if (state_reg == rst_irq_pkg::ST_FETCH && fetch_reg == FETCH_LAST) begin
         running_reg <= 1'b1;
      end
   end

   // Watchdog drives the pin only a few cycles: too short for board resets
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         wdg_cnt_reg <= 3'h0;
      end else if (i_wdg_reset) begin
         wdg_cnt_reg <= 3'(rst_irq_pkg::WDG_PULSE_CYCLES);
      end else if (wdg_cnt_reg != 3'h0) begin
         wdg_cnt_reg <= wdg_cnt_reg - 3'h1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_reset_pin_oe    <= 1'b0;
         o_reset_pin_n_out <= 1'b1;
         o_core_reset      <= 1'b1;
         o_ports_pullup    <= 1'b1;
         o_osc_restart     <= 1'b0;
         o_stack_clear     <= 1'b0;
      end else begin
         o_reset_pin_oe    <= i_supply_voltage_monitor || (wdg_cnt_reg != 3'h0);
         o_reset_pin_n_out <= 1'b0;
         o_core_reset      <= !running_reg || rst_event;
         o_ports_pullup    <= !running_reg || rst_event;
         o_osc_restart     <= rst_event && running_reg;
         o_stack_clear     <= (state_reg == rst_irq_pkg::ST_FETCH);
      end
   end

   // ==========================================================
   // Interrupt latches
   logic       nmi_req_reg;
   logic [1:0] ext_req_reg;
   logic       ext1_level;
   logic       in_nmi_reg;
   logic       in_irq_reg;
   logic       take_nmi;
   logic       take_mask;
   logic [1:0] sel;
   logic [3:0] pend;

   assign ext1_level = level_mode && (ext1_lvl != {EXT_LINES{1'b1}});

   always_ff @(posedge i_mclk) begin
      if (i_rst || !running_reg) begin
         ext1_prev_reg <= {EXT_LINES{1'b1}};
         ext2_prev_reg <= {EXT_LINES{1'b1}};
      end else begin
         ext1_prev_reg <= ext1_lvl;
         ext2_prev_reg <= ext2_lvl;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst || !running_reg) begin
         nmi_req_reg <= 1'b0;
         ext_req_reg <= 2'b00;
      end else begin
         // Set wins over the clear by acceptance
         if (nmi_fall) begin
            nmi_req_reg <= 1'b1;
         end else if (take_nmi) begin
            nmi_req_reg <= 1'b0;
         end
         if (!level_mode && |(ext1_prev_reg & ~ext1_lvl)) begin
            ext_req_reg[0] <= 1'b1;
         end else if (take_mask && sel == 2'd0) begin
            ext_req_reg[0] <= 1'b0;
         end
         if (|(rise_mode ? (~ext2_prev_reg & ext2_lvl) : (ext2_prev_reg & ~ext2_lvl))) begin
            ext_req_reg[1] <= 1'b1;
         end else if (take_mask && sel == 2'd1) begin
            ext_req_reg[1] <= 1'b0;
         end
      end
   end

   // Peripheral flags stay until software writes a one to clear
   logic [1:0] periph_evt;
   logic [1:0] periph_clr;
   assign periph_evt = {|i_adc_evt, |i_timer_evt};
   assign periph_clr = (i_wr && i_addr == rst_irq_pkg::ADDR_PERIPH_FLAG) ? i_wdata[1:0] : 2'b00;
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         periph_flag_reg <= 2'b00;
      end else begin
         periph_flag_reg <= periph_evt | (periph_flag_reg & ~periph_clr);
      end
   end

   assign pend = {periph_flag_reg & periph_en_reg, ext_req_reg[1], ext_req_reg[0] | ext1_level};
   // A reset seen this cycle wins over any interrupt vector load
   assign take_nmi  = running_reg && !rst_event && nmi_req_reg && !in_nmi_reg;
   assign take_mask = running_reg && !rst_event && !take_nmi && global_irq_enable &&
                      !in_irq_reg && !in_nmi_reg && (pend != 4'h0);

   function automatic logic [1:0] prio_sel(input logic [3:0] p);
      prio_sel = 2'd3;
      for (int i = 3; i >= 0; i--) begin
         if (p[i]) begin
            prio_sel = 2'(i);
         end
      end
   endfunction
   assign sel = prio_sel(pend);

   // ==========================================================
   // Mode flags and PC load
   always_ff @(posedge i_mclk) begin
      if (i_rst || rst_event || !running_reg) begin
         in_nmi_reg <= 1'b1;
         in_irq_reg <= 1'b0;
      end else if (take_nmi) begin
         in_nmi_reg <= 1'b1;
      end else if (i_return_from_interrupt_instr) begin
         if (in_nmi_reg) begin
            in_nmi_reg <= 1'b0;
         end else begin
            in_irq_reg <= 1'b0;
         end
      end else if (take_mask) begin
         in_irq_reg <= 1'b1;
      end
   end
   // In-service maskable remains set underneath a preempting NMI
   assign o_nmi_mode = in_nmi_reg;
   assign o_irq_mode = in_irq_reg;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_pc_load   <= 1'b0;
         o_pc_vector <= rst_irq_pkg::RESET_VECTOR;
      end else begin
         o_pc_load <= (state_reg == rst_irq_pkg::ST_FETCH && fetch_reg == 2'h0) ||
                      take_nmi || take_mask;
         if (state_reg == rst_irq_pkg::ST_FETCH) begin
            o_pc_vector <= rst_irq_pkg::RESET_VECTOR;
         end else if (take_nmi) begin
            o_pc_vector <= rst_irq_pkg::NMI_VECTOR;
         end else if (take_mask) begin
            case (sel)
               2'd0:    o_pc_vector <= rst_irq_pkg::VEC1_ADDR;
               2'd1:    o_pc_vector <= rst_irq_pkg::VEC2_ADDR;
               2'd2:    o_pc_vector <= rst_irq_pkg::VEC3_ADDR;
               default: o_pc_vector <= rst_irq_pkg::VEC4_ADDR;
            endcase
         end
      end
   end

   // Wake, only while global_irq_enable is set: any request ends wait; only stop-capable ones end stop
   logic any_req;
   logic stop_req;
   assign any_req  = global_irq_enable && (pend != 4'h0 || nmi_req_reg);
   assign stop_req = global_irq_enable &&
                     ((pend & rst_irq_pkg::STOP_CAPABLE) != 4'h0 || nmi_req_reg);
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_wake <= 1'b0;
      end else begin
         o_wake <= (i_wait_mode && any_req) || (i_stop_mode && stop_req);
      end
   end

   // ==========================================================
   // Register port
   always_ff @(posedge i_mclk) begin
      if (i_rst || rst_event) begin
         option_reg    <= rst_irq_pkg::OPT_RESET;
         periph_en_reg <= 2'b00;
      end else if (i_wr) begin
         case (i_addr)
            rst_irq_pkg::ADDR_OPTION:    option_reg    <= i_wdata;
            rst_irq_pkg::ADDR_PERIPH_EN: periph_en_reg <= i_wdata[1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            rst_irq_pkg::ADDR_STATUS:      o_rdata <= {2'b00, nmi_lvl, nmi_req_reg, ext_req_reg,
                                                       in_nmi_reg, in_irq_reg};
            rst_irq_pkg::ADDR_PERIPH_EN:   o_rdata <= {6'h00, periph_en_reg};
            rst_irq_pkg::ADDR_PERIPH_FLAG: o_rdata <= {6'h00, periph_flag_reg};
            default:                       o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end
endmodule

// file: tb/reset_and_interrupt_control_properties.sv
// Port checks for the reset sequencer and interrupt arbiter
`timescale 1ns/100ps
module reset_and_interrupt_control_properties #(
   parameter int RESET_DELAY = 16
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_reset_pin_n,
   input  wire logic        o_reset_pin_n_out,
   input  wire logic        o_reset_pin_oe,
   input  wire logic        i_wdg_reset,
   input  wire logic        i_supply_voltage_monitor,
   input  wire logic        o_core_reset,
   input  wire logic        o_ports_pullup,
   input  wire logic        o_osc_restart,
   input  wire logic        o_stack_clear,
   input  wire logic        o_pc_load,
   input  wire logic [11:0] o_pc_vector,
   input  wire logic        o_nmi_mode,
   input  wire logic        o_irq_mode
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // ==========================================
   // Quiet time since the last raw reset cause
   int quiet_reg;
   always_ff @(posedge i_mclk) begin
      if (i_rst || !i_reset_pin_n || i_wdg_reset || i_supply_voltage_monitor) begin
         quiet_reg <= 0;
      end else if (quiet_reg < 100000) begin
         quiet_reg <= quiet_reg + 1;
      end
   end
   // ==========================================
   // Assertions
   chk_reset_outputs: assert property ($fell(i_rst) |-> o_core_reset && o_ports_pullup)
      else $error("core left reset state at reset release");
   chk_osc_restart: assert property ($rose(o_core_reset) |-> o_osc_restart)
      else $error("reset during run did not restart the oscillator");
   chk_pin_drive_low: assert property (o_reset_pin_oe |-> !o_reset_pin_n_out)
      else $error("reset pin enabled but not driven low");
   chk_supply_pin: assert property (i_supply_voltage_monitor [*2] |-> o_reset_pin_oe && o_core_reset)
      else $error("low supply without static reset");
   chk_wdg_pin: assert property (i_wdg_reset |-> ##[1:2] o_reset_pin_oe)
      else $error("watchdog reset did not pull the pin");
   chk_fetch_len: assert property ($rose(o_stack_clear) |-> o_stack_clear ##1 o_stack_clear ##1 !o_stack_clear)
      else $error("vector fetch not two cycles");
   chk_reset_vector: assert property (o_core_reset && o_pc_load |-> o_pc_vector == rst_irq_pkg::RESET_VECTOR)
      else $error("reset fetch loaded wrong vector");
   chk_delay_min: assert property ($rose(o_stack_clear) |-> quiet_reg >= RESET_DELAY)
      else $error("fetch started before the reset delay ran out");
   chk_release_mode: assert property ($fell(o_core_reset) |-> o_nmi_mode && $past(o_stack_clear))
      else $error("core released without fetch or outside interrupt mode");
   chk_nmi_no_nest: assert property (o_nmi_mode && $past(o_nmi_mode) && o_pc_load |-> o_core_reset)
      else $error("vector taken inside non-maskable service");
   chk_irq_no_nest: assert property (o_irq_mode && $past(o_irq_mode) && o_pc_load
      |-> o_pc_vector == rst_irq_pkg::NMI_VECTOR || o_core_reset)
      else $error("maskable vector nested");
endmodule

// file: tb/core_partner.sv
// Behavioural model of the core program counter and return logic
`timescale 1ns/100ps
module core_partner (
   input  wire logic        i_mclk,
   input  wire logic        i_pc_load,
   input  wire logic [11:0] i_pc_vector,
   input  wire logic        i_core_reset,
   input  wire logic        i_ret_req,
   input  wire logic [3:0]  i_ret_lag,
   output logic             o_ret,
   output logic [11:0]      o_last_vector
);
   // Lag lets the service routine end promptly or slowly
   int lag_reg;
   initial begin
      o_ret = 1'b0;
      o_last_vector = 12'h000;
      lag_reg = -1;
   end
   always @(posedge i_mclk) begin
      o_ret <= 1'b0;
      if (i_pc_load) begin
         o_last_vector <= i_pc_vector;
      end
      if (i_core_reset) begin
         lag_reg <= -1;
      end else if (i_ret_req) begin
         lag_reg <= i_ret_lag;
      end else if (lag_reg == 0) begin
         o_ret <= 1'b1;
         lag_reg <= -1;
      end else if (lag_reg > 0) begin
         lag_reg <= lag_reg - 1;
      end
   end
endmodule

// file: tb/reset_and_interrupt_control_bench.sv
// Self-checking bench for the reset sequencer and interrupt arbiter
`timescale 1ns/100ps
module reset_and_interrupt_control_bench;
   localparam int RD = 16;
   logic        i_mclk, i_rst, pin_drv_n, i_wdg_reset, i_supply_voltage_monitor, i_nmi_pin_n;
   logic [5:0]  i_ext1_n, i_ext2;
   logic        i_timer_evt, i_adc_evt, i_wait_mode, i_stop_mode, ret, ret_req, i_wr, i_rd;
   logic [3:0]  ret_lag;
   logic [1:0]  i_addr;
   logic [7:0]  i_wdata, o_rdata;
   logic        o_pin_out, o_pin_oe, o_core_reset, o_stack_clear, o_ports_pullup;
   logic        o_pc_load, o_nmi_mode, o_irq_mode, o_wake;
   logic [11:0] o_pc_vector, last_vec;
   logic [31:0] seed;
   int          failures, n_compared, cycles;
   // Pull-up on the pin; the device only ever pulls low
   wire         pin_n = pin_drv_n & ~(o_pin_oe & ~o_pin_out);

   reset_and_interrupt_control #(.RESET_DELAY(RD)) i_dut (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_reset_pin_n(pin_n), .o_reset_pin_n_out(o_pin_out),
      .o_reset_pin_oe(o_pin_oe), .i_wdg_reset(i_wdg_reset),
      .i_supply_voltage_monitor(i_supply_voltage_monitor), .i_nmi_pin_n(i_nmi_pin_n),
      .i_ext1_n(i_ext1_n), .i_ext2(i_ext2), .i_timer_evt(i_timer_evt), .i_adc_evt(i_adc_evt),
      .i_wait_mode(i_wait_mode), .i_stop_mode(i_stop_mode),
      .i_return_from_interrupt_instr(ret), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_core_reset(o_core_reset),
      .o_stack_clear(o_stack_clear), .o_ports_pullup(o_ports_pullup), .o_osc_restart(),
      .o_pc_load(o_pc_load), .o_pc_vector(o_pc_vector), .o_nmi_mode(o_nmi_mode),
      .o_irq_mode(o_irq_mode), .o_wake(o_wake));
   core_partner i_core (.i_mclk(i_mclk), .i_pc_load(o_pc_load), .i_pc_vector(o_pc_vector),
      .i_core_reset(o_core_reset), .i_ret_req(ret_req), .i_ret_lag(ret_lag), .o_ret(ret),
      .o_last_vector(last_vec));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   // ==========================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, exp);
   endtask
   // Waits for a vector load, which must land in cycle window [lo, hi)
   task automatic wait_load(input logic [11:0] exp, input int lo, input int hi);
      int n;
      n = 0;
      do begin
         @(posedge i_mclk);
         #1 n++;
      end while (o_pc_load !== 1'b1 && n < hi);
      chk(12'(n >= lo && n < hi), 12'h001);
      chk(o_pc_vector, exp);
      @(posedge i_mclk);
      #1 chk(last_vec, exp);
   endtask
   task automatic no_load(input int n);
      repeat (n) begin
         @(posedge i_mclk);
         #1 chk(12'(o_pc_load), 12'h000);
      end
   endtask
   task automatic ret_now();
      ret_lag <= 4'(rnd() % 8);
      ret_req <= 1'b1;
      @(posedge i_mclk);
      ret_req <= 1'b0;
   endtask
   task automatic test_done();
      $display("compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Timeout ceiling is several times the expected run
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         test_done();
      end
   end
   // ==========================================
   // Scenarios
   initial begin
      {i_rst, pin_drv_n, i_nmi_pin_n} = 3'b111;
      {i_wdg_reset, i_supply_voltage_monitor, i_timer_evt, i_adc_evt} = 4'h0;
      {i_wait_mode, i_stop_mode, ret_req, i_wr, i_rd} = 5'h00;
      {i_ext1_n, i_ext2} = 12'hFFF;
      {i_addr, i_wdata, ret_lag} = 14'h0000;
      {seed, failures, n_compared, cycles} = {32'd28193, 96'h0};
      tick(12);
      #1 chk(o_ports_pullup, 1'b1);
      i_rst <= 1'b0;
      wait_load(rst_irq_pkg::RESET_VECTOR, RD, RD + 10);
      tick(2);
      #1 chk(o_nmi_mode, 1'b1);
      ret_now();
      tick(12);
      #1 chk(o_nmi_mode, 1'b0);
      wr(rst_irq_pkg::ADDR_OPTION, 8'h00);
      tick(1);
      wr(rst_irq_pkg::ADDR_PERIPH_EN, 8'h03);
      i_timer_evt <= 1'b1;
      i_adc_evt <= 1'b1;
      i_ext1_n[rnd() % 6] <= 1'b0;
      i_ext2[rnd() % 6] <= 1'b0;
      tick(1);
      {i_timer_evt, i_adc_evt} <= 2'b00;
      no_load(10);
      i_ext1_n <= 6'h3F;
      i_ext2 <= 6'h3F;
      rd(rst_irq_pkg::ADDR_PERIPH_FLAG, 8'h03);
      i_wait_mode <= 1'b1;
      wr(rst_irq_pkg::ADDR_OPTION, 8'h10);
      wait_load(rst_irq_pkg::VEC1_ADDR, 0, 10);
      chk(o_wake, 1'b1);
      i_wait_mode <= 1'b0;
      no_load(6);
      ret_now();
      wait_load(rst_irq_pkg::VEC2_ADDR, 0, 20);
      ret_now();
      wait_load(rst_irq_pkg::VEC3_ADDR, 0, 20);
      wr(rst_irq_pkg::ADDR_PERIPH_FLAG, 8'h01);
      ret_now();
      wait_load(rst_irq_pkg::VEC4_ADDR, 0, 20);
      i_nmi_pin_n <= 1'b0;
      wait_load(rst_irq_pkg::NMI_VECTOR, 0, 10);
      i_nmi_pin_n <= 1'b1;
      ret_now();
      tick(12);
      #1 chk({o_nmi_mode, o_irq_mode}, 2'b01);
      i_wdg_reset <= 1'b1;
      tick(1);
      i_wdg_reset <= 1'b0;
      tick(2);
      #1 chk({o_pin_oe, o_core_reset}, 2'b11);
      wait_load(rst_irq_pkg::RESET_VECTOR, RD, RD + 20);
      tick(3);
      #1 chk({o_irq_mode, o_pin_oe}, 2'b00);
      i_stop_mode <= 1'b1;
      pin_drv_n <= 1'b0;
      tick(5 + rnd() % 4);
      #1 chk(o_ports_pullup, 1'b1);
      pin_drv_n <= 1'b1;
      tick(RD / 2);
      pin_drv_n <= 1'b0;
      tick(4);
      pin_drv_n <= 1'b1;
      i_stop_mode <= 1'b0;
      wait_load(rst_irq_pkg::RESET_VECTOR, RD, RD + 10);
      tick(4);
      i_supply_voltage_monitor <= 1'b1;
      tick(30);
      #1 chk({o_pin_oe, o_core_reset}, 2'b11);
      i_supply_voltage_monitor <= 1'b0;
      wait_load(rst_irq_pkg::RESET_VECTOR, RD, RD + 12);
      tick(4);
      test_done();
   end
endmodule
bind reset_and_interrupt_control reset_and_interrupt_control_properties #(
   .RESET_DELAY(RESET_DELAY)) i_chk (.*);
